//--- rtl/tcc_pkg.sv
// Constants and types of the timer capture/compare block
package tcc_pkg;
    localparam int CW = 16;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SLAVE = 8'h04;
    localparam logic [7:0] ADDR_EVGEN = 8'h08;
    localparam logic [7:0] ADDR_MODE = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_COUNT = 8'h14;
    localparam logic [7:0] ADDR_RELOAD = 8'h18;
    localparam logic [7:0] ADDR_VAL0 = 8'h1c;
    localparam logic [7:0] ADDR_VAL1 = 8'h20;
    localparam logic [7:0] ADDR_FLAG = 8'h24;
    localparam logic [7:0] ADDR_MISS = 8'h28;
    localparam logic [7:0] ADDR_MASK = 8'h2c;
    localparam int CR_CEN = 0;
    localparam int CR_ARBE = 7;
    localparam int SL_SMS = 0;
    localparam int SL_TS = 4;
    localparam int EG_UG = 0;
    localparam int EG_CC = 1;
    localparam int MD_STRIDE = 16;
    localparam int MD_CCS = 0;
    localparam int MD_PSC = 2;
    localparam int MD_FLT = 4;
    localparam int MD_OCBE = 8;
    localparam int MD_OCM = 9;
    localparam int EN_STRIDE = 4;
    localparam int EN_CCE = 0;
    localparam int EN_CCP = 1;
    localparam int FL_CH = 1;
    localparam logic [1:0] CCS_OUT = 2'h0;
    localparam logic [1:0] CCS_CROSS = 2'h2;
    localparam logic [2:0] SMS_RESET = 3'h4;
    localparam logic [2:0] TS_IN0 = 3'h5;
    localparam logic [2:0] TS_IN1 = 3'h6;
    localparam logic [3:0] FILT_OFF = 4'h0;
    localparam logic [3:0] FILT_8 = 4'h3;
    localparam logic [2:0] FILT_LAST = 3'h7;
    localparam logic [CW-1:0] RELOAD_RST = 16'hffff;
    typedef enum logic [2:0] {
        OC_FROZEN = 3'b000,
        OC_SET = 3'b001,
        OC_CLR = 3'b010,
        OC_TOG = 3'b011,
        OC_FLOW = 3'b100,
        OC_FHIGH = 3'b101,
        OC_PWM1 = 3'b110,
        OC_PWM2 = 3'b111
    } tcc_ocm_t;
endpackage

//--- rtl/tcc_timer_cc.sv
// Two-channel timer with capture/compare channels and APB registers
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_cc
    import tcc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer pins
    input wire logic [1:0] timerIn,
    output logic [1:0] chanOut,
    output logic [1:0] chanOutEn,
    // Interrupt request
    output logic irqReq
);
    typedef struct packed {
        logic cen;
        logic arbe;
        logic [2:0] sms;
        logic [2:0] ts;
        logic [1:0][1:0] ccs;
        logic [1:0][1:0] psc;
        logic [1:0][3:0] flt;
        logic [1:0] ocbe;
        logic [1:0][2:0] ocm;
        logic [1:0][2:0] ocmD;
        logic [1:0] cce;
        logic [1:0] ccp;
        logic [CW-1:0] cnt;
        logic [CW-1:0] arr;
        logic [CW-1:0] arrShd;
        logic [1:0][CW-1:0] buff;
        logic [1:0][CW-1:0] shd;
        logic [1:0] capPend;
        logic [1:0][2:0] pcnt;
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] flev;
        logic [1:0] flevD;
        logic [1:0][2:0] fcnt;
        logic [1:0] eqD;
        logic [1:0] ltD;
        logic [1:0] refLvl;
        logic [1:0] pin;
        logic [1:0] oe;
        logic [2:0] flg;
        logic [1:0] miss;
        logic [2:0] mask;
        logic [31:0] rdata;
        logic err;
    } tcc_state_t;

    tcc_state_t s;
    tcc_state_t next_s;
    logic wr;
    logic rd;
    logic ug;
    logic trg;
    logic ovf;
    logic update_event;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] chEdge;
    logic [1:0] gen;
    logic [1:0] capNow;
    logic [1:0] match;
    logic [1:0] lt;

    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;

    // Read data is latched in the setup cycle, so the access phase needs no wait
    function automatic logic [32:0] rdWord(input tcc_state_t st, input logic [7:0] a);
        logic [32:0] r;
        r = '0;
        case (a)
            ADDR_CTRL: begin
                r[CR_CEN] = st.cen;
                r[CR_ARBE] = st.arbe;
            end
            ADDR_SLAVE: begin
                r[SL_SMS +: 3] = st.sms;
                r[SL_TS +: 3] = st.ts;
            end
            ADDR_EVGEN: r = '0;
            ADDR_MODE: begin
                for (int y = 0; y < 2; y++) begin
                    r[y*MD_STRIDE + MD_CCS +: 2] = st.ccs[y];
                    r[y*MD_STRIDE + MD_PSC +: 2] = st.psc[y];
                    r[y*MD_STRIDE + MD_FLT +: 4] = st.flt[y];
                    r[y*MD_STRIDE + MD_OCBE] = st.ocbe[y];
                    r[y*MD_STRIDE + MD_OCM +: 3] = st.ocm[y];
                end
            end
            ADDR_ENABLE: begin
                for (int y = 0; y < 2; y++) begin
                    r[y*EN_STRIDE + EN_CCE] = st.cce[y];
                    r[y*EN_STRIDE + EN_CCP] = st.ccp[y];
                end
            end
            ADDR_COUNT: r[CW-1:0] = st.cnt;
            ADDR_RELOAD: r[CW-1:0] = st.arr;
            ADDR_VAL0: r[CW-1:0] = st.buff[0];
            ADDR_VAL1: r[CW-1:0] = st.buff[1];
            ADDR_FLAG: r[2:0] = st.flg;
            ADDR_MISS: r[FL_CH +: 2] = st.miss;
            ADDR_MASK: r[2:0] = st.mask;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction

    always_comb begin
        next_s = s;
        rise = '0;
        fall = '0;
        chEdge = '0;
        gen = '0;
        capNow = '0;
        match = '0;
        lt = '0;
        // Two-stage synchroniser; only the second stage feeds the filter
        next_s.s1 = timerIn;
        next_s.s2 = s.s1;
        for (int i = 0; i < 2; i++) begin
            next_s.flevD[i] = s.flev[i];
            // Every non-zero filter code uses the eight-sample window
            if (s.flt[i] == FILT_OFF) begin
                next_s.flev[i] = s.s2[i];
                next_s.fcnt[i] = '0;
            end else if (s.s2[i] != s.flev[i]) begin
                if (s.fcnt[i] == FILT_LAST) begin
                    next_s.flev[i] = s.s2[i];
                    next_s.fcnt[i] = '0;
                end else begin
                    next_s.fcnt[i] = s.fcnt[i] + 3'h1;
                end
            end else begin
                next_s.fcnt[i] = '0;
            end
            rise[i] = s.flev[i] & ~s.flevD[i];
            fall[i] = ~s.flev[i] & s.flevD[i];
        end
        // Counter reset on trigger from either polarised input
        trg = (s.sms == SMS_RESET) &&
            ((s.ts == TS_IN0 && (s.ccp[0] ? fall[0] : rise[0])) ||
             (s.ts == TS_IN1 && (s.ccp[1] ? fall[1] : rise[1])));
        ug = wr && paddr == ADDR_EVGEN && pwdata[EG_UG];
        ovf = s.cen && s.cnt == s.arrShd && !ug && !trg;
        update_event = ug | trg | ovf;
        if (ug || trg) begin
            next_s.cnt = '0;
        end else if (s.cen) begin
            next_s.cnt = ovf ? '0 : s.cnt + 16'h0001;
        end
        if (!s.arbe || update_event) begin
            next_s.arrShd = s.arr;
        end
        // Clears come first so that a set in the same cycle wins
        if (wr && paddr == ADDR_FLAG) begin
            next_s.flg = s.flg & ~pwdata[2:0];
        end
        if (wr && paddr == ADDR_MISS) begin
            next_s.miss = s.miss & ~pwdata[FL_CH +: 2];
        end
        if (rd && paddr == ADDR_VAL0) begin
            next_s.flg[FL_CH] = 1'b0;
        end
        if (rd && paddr == ADDR_VAL1) begin
            next_s.flg[FL_CH+1] = 1'b0;
        end
        if (update_event) begin
            next_s.flg[0] = 1'b1;
        end
        for (int y = 0; y < 2; y++) begin
            gen[y] = wr && paddr == ADDR_EVGEN && pwdata[EG_CC+y];
            next_s.ocmD[y] = s.ocm[y];
            if (s.ccs[y] == CCS_CROSS) begin
                chEdge[y] = s.ccp[y] ? fall[1-y] : rise[1-y];
            end else begin
                chEdge[y] = s.ccp[y] ? fall[y] : rise[y];
            end
            if (s.ccs[y] != CCS_OUT) begin
                if (s.cce[y] && chEdge[y]) begin
                    if (s.pcnt[y] == 3'(~(3'b111 << s.psc[y]))) begin
                        capNow[y] = 1'b1;
                        next_s.pcnt[y] = '0;
                    end else begin
                        next_s.pcnt[y] = s.pcnt[y] + 3'h1;
                    end
                end
                capNow[y] = capNow[y] | gen[y];
                next_s.capPend[y] = 1'b0;
                if (s.capPend[y]) begin
                    next_s.buff[y] = s.shd[y];
                end
                if (capNow[y]) begin
                    next_s.shd[y] = s.cnt;
                    next_s.capPend[y] = 1'b1;
                    next_s.flg[FL_CH+y] = 1'b1;
                    if (s.flg[FL_CH+y]) begin
                        next_s.miss[y] = 1'b1;
                    end
                end
                next_s.eqD[y] = 1'b0;
                next_s.oe[y] = 1'b0;
                next_s.pin[y] = 1'b0;
            end else begin
                next_s.capPend[y] = 1'b0;
                next_s.pcnt[y] = '0;
                if (!s.ocbe[y] || update_event) begin
                    next_s.shd[y] = s.buff[y];
                end
                lt[y] = s.cnt < s.shd[y];
                next_s.eqD[y] = s.cnt == s.shd[y];
                next_s.ltD[y] = lt[y];
                // One match per arrival at the compare value, even if the counter stops there
                match[y] = (s.cnt == s.shd[y]) && !s.eqD[y];
                if (match[y] || gen[y]) begin
                    next_s.flg[FL_CH+y] = 1'b1;
                end
                // Update events never touch the reference here
                case (tcc_ocm_t'(s.ocm[y]))
                    OC_FROZEN: next_s.refLvl[y] = s.refLvl[y];
                    OC_SET: if (match[y]) next_s.refLvl[y] = 1'b1;
                    OC_CLR: if (match[y]) next_s.refLvl[y] = 1'b0;
                    OC_TOG: if (match[y]) next_s.refLvl[y] = ~s.refLvl[y];
                    OC_FLOW: next_s.refLvl[y] = 1'b0;
                    OC_FHIGH: next_s.refLvl[y] = 1'b1;
                    OC_PWM1: begin
                        if (lt[y] != s.ltD[y] || s.ocmD[y] == OC_FROZEN) begin
                            next_s.refLvl[y] = lt[y];
                        end
                    end
                    OC_PWM2: begin
                        if (lt[y] != s.ltD[y] || s.ocmD[y] == OC_FROZEN) begin
                            next_s.refLvl[y] = ~lt[y];
                        end
                    end
                    default: next_s.refLvl[y] = s.refLvl[y];
                endcase
                next_s.oe[y] = s.cce[y];
                next_s.pin[y] = s.cce[y] & (next_s.refLvl[y] ^ s.ccp[y]);
            end
        end
        if (wr) begin
            case (paddr)
                ADDR_CTRL: begin
                    next_s.cen = pwdata[CR_CEN];
                    next_s.arbe = pwdata[CR_ARBE];
                end
                ADDR_SLAVE: begin
                    next_s.sms = pwdata[SL_SMS +: 3];
                    next_s.ts = pwdata[SL_TS +: 3];
                end
                ADDR_MODE: begin
                    for (int y = 0; y < 2; y++) begin
                        next_s.ccs[y] = pwdata[y*MD_STRIDE + MD_CCS +: 2];
                        next_s.psc[y] = pwdata[y*MD_STRIDE + MD_PSC +: 2];
                        next_s.flt[y] = pwdata[y*MD_STRIDE + MD_FLT +: 4];
                        next_s.ocbe[y] = pwdata[y*MD_STRIDE + MD_OCBE];
                        next_s.ocm[y] = pwdata[y*MD_STRIDE + MD_OCM +: 3];
                    end
                end
                ADDR_ENABLE: begin
                    for (int y = 0; y < 2; y++) begin
                        next_s.cce[y] = pwdata[y*EN_STRIDE + EN_CCE];
                        next_s.ccp[y] = pwdata[y*EN_STRIDE + EN_CCP];
                    end
                end
                ADDR_RELOAD: next_s.arr = pwdata[CW-1:0];
                ADDR_VAL0: if (s.ccs[0] == CCS_OUT) next_s.buff[0] = pwdata[CW-1:0];
                ADDR_VAL1: if (s.ccs[1] == CCS_OUT) next_s.buff[1] = pwdata[CW-1:0];
                ADDR_MASK: next_s.mask = pwdata[2:0];
                default: next_s.err = s.err;
            endcase
        end
        if (psel && !penable) begin
            {next_s.err, next_s.rdata} = rdWord(s, paddr);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            s <= '0;
            s.arr <= RELOAD_RST;
            s.arrShd <= RELOAD_RST;
            // Counter and compare shadows both start at zero, so the first cycle must not count as an arrival
            s.eqD <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & s.err;
    assign chanOut = s.pin;
    assign chanOutEn = s.oe;
    assign irqReq = |(s.flg & s.mask);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    property p_sync;
        ##2 s.s2 == $past(timerIn, 2);
    endproperty
    a_sync: assert property (p_sync) else $error("input not synchronised");

    property p_filt;
        $rose(s.flev[0]) && $past(s.flt[0]) == FILT_8 |-> $past(s.s2[0], 1) && $past(s.s2[0], 8);
    endproperty
    a_filt: assert property (p_filt) else $error("filter accepted early");

    property p_cap;
        capNow[0] |=> s.shd[0] == $past(s.cnt) ##1 s.buff[0] == $past(s.cnt, 2);
    endproperty
    a_cap: assert property (p_cap) else $error("capture not moved to buffer");

    property p_miss;
        capNow[1] && s.flg[FL_CH+1] |=> s.miss[1] && s.flg[FL_CH+1];
    endproperty
    a_miss: assert property (p_miss) else $error("missed capture not flagged");

    property p_ro;
        wr && paddr == ADDR_VAL0 && s.ccs[0] != CCS_OUT && !s.capPend[0] |=> $stable(s.buff[0]);
    endproperty
    a_ro: assert property (p_ro) else $error("input value register written");

    property p_rdclr;
        rd && paddr == ADDR_VAL0 && !capNow[0] && s.ccs[0] != CCS_OUT |=> !s.flg[FL_CH];
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("read did not clear flag");

    property p_force;
        s.ocm[0] == OC_FHIGH && s.ccs[0] == CCS_OUT && s.cce[0] && $stable(s.ccp[0]) |=> chanOut[0] == ~s.ccp[0];
    endproperty
    a_force: assert property (p_force) else $error("forced level wrong");

    property p_shadow;
        s.ccs[0] == CCS_OUT && s.ocbe[0] && !update_event |=> $stable(s.shd[0]);
    endproperty
    a_shadow: assert property (p_shadow) else $error("shadow loaded without update");

    property p_pwm;
        s.ccs[0] == CCS_OUT && s.ocm[0] == OC_PWM1 && s.ocmD[0] == OC_PWM1 && lt[0] != s.ltD[0]
            |=> s.refLvl[0] == $past(lt[0]);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm reference wrong");

    property p_ovf;
        ovf |=> s.cnt == '0 && s.flg[0];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow without update");

    c_miss: cover property (capNow[0] && s.flg[FL_CH]);
    c_pwm: cover property (s.ocm[0] == OC_PWM1 && $rose(s.refLvl[0]));
    c_trg: cover property (trg);
    c_cap: cover property (capNow[0] && !s.flg[FL_CH]);
    c_tog: cover property (s.ocm[0] == OC_TOG && match[0]);
endmodule
`default_nettype wire

//--- verif/tcc_pin_model.sv
// Pin-side model: drives the timer inputs and measures channel output duty
`timescale 1ns/1ns
`default_nettype none
module tcc_pin_model (
    // Clock
    input wire logic clk_sys,
    // Timer pins
    output logic [1:0] timerIn,
    input wire logic [1:0] chanOut,
    // Duty measurement
    input wire logic countOn,
    output var int highCount
);
    initial begin
        timerIn = 2'h0;
        highCount = 0;
    end

    // Input two stays low: shared-input measurement routes input one to both channels
    task automatic drive(input logic level, input int cycles);
        timerIn[0] <= level;
        repeat (cycles) @(posedge clk_sys);
    endtask

    // Accumulates only while enabled, so the bench measures by difference
    // Falling edge: the registered output has settled by then
    always @(negedge clk_sys) begin
        if (countOn) begin
            highCount <= highCount + int'(chanOut[0]);
        end
    end
endmodule
`default_nettype wire

//--- verif/tcc_timer_cc_bench.sv
// Self-checking bench for the two-channel timer capture/compare block
`timescale 1ns/1ns
`default_nettype none
module tcc_timer_cc_bench
    import tcc_pkg::*;
;
    logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irqReq, countOn;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, a0;
    logic [1:0] timerIn, chanOut, chanOutEn;
    logic [65:0] expQ[$];
    logic [65:0] ent;
    logic [31:0] per[2], wid[2];
    int n_errors, samples_checked, highCount, seed, v, c, d, h0;
    int hi[2], lo[2];

    tcc_timer_cc dut_u (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timerIn(timerIn), .chanOut(chanOut), .chanOutEn(chanOutEn), .irqReq(irqReq));
    tcc_pin_model pin_u (.clk_sys(clk_sys), .timerIn(timerIn), .chanOut(chanOut), .countOn(countOn),
        .highCount(highCount));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Read expectations carry a mask over {pslverr, prdata}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat, input logic [32:0] m,
        input logic [32:0] e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk_sys);
        penable <= 1'b1;
        if (!w) expQ.push_back({m, e});
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat, 33'h0, 33'h0);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b1, 32'hffffffff}, {1'b0, e});
    endtask

    function automatic logic [31:0] md(input logic [2:0] ocm, input logic be, input logic [1:0] ccs,
        input logic [3:0] flt);
        return (32'(ocm) << MD_OCM) | (32'(be) << MD_OCBE) | (32'(ccs) << MD_CCS) | (32'(flt) << MD_FLT);
    endfunction

    always @(posedge clk_sys) begin
        if (psel && penable && pready && !pwrite) begin
            ent = expQ.pop_front();
            samples_checked++;
            if (({pslverr, prdata} & ent[65:33]) !== ent[32:0]) begin
                n_errors++;
                $display("Error at %0t: read %h gave %h expected %h", $time, paddr, prdata, ent[31:0]);
            end
        end
    end

    task automatic results();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        $display("Error at %0t: run did not finish", $time);
        results();
    end

    initial begin
        seed = 62851;
        {psel, penable, pwrite, countOn, nrst} = 5'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rdx(ADDR_RELOAD, 32'h0000ffff);
        rdx(ADDR_FLAG, 32'h0);
        apb(1'b0, 8'h40, 32'h0, {1'b1, 32'hffffffff}, {1'b1, 32'h0});
        v = 40 + ($random(seed) & 63);
        wr(ADDR_VAL0, 32'(v));
        rdx(ADDR_VAL0, 32'(v));
        wr(ADDR_MASK, 32'h2);
        wr(ADDR_CTRL, 32'h1);
        // Forced levels for both output polarities
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_ENABLE, 32'h1 | (32'(p) << EN_CCP));
            wr(ADDR_MODE, md(OC_FHIGH, 1'b0, CCS_OUT, FILT_OFF));
            wr(ADDR_EVGEN, 32'h1);
            // The update flag is cleared too, so only channel one's match at count v is seen
            wr(ADDR_FLAG, 32'h7);
            repeat (v + 10) @(posedge clk_sys);
            check(32'({chanOutEn[0], chanOut[0]}), {30'h0, 1'b1, ~p[0]}, "forced high");
            check(32'(irqReq), 32'h1, "irq on forced match");
            rdx(ADDR_FLAG, 32'h2);
            wr(ADDR_FLAG, 32'h2);
            check(32'(irqReq), 32'h0, "irq after clear");
            wr(ADDR_MODE, md(OC_FLOW, 1'b0, CCS_OUT, FILT_OFF));
            @(posedge clk_sys);
            check(32'(chanOut[0]), 32'(p), "forced low");
        end
        // Match actions: freeze, set, clear, toggle
        wr(ADDR_ENABLE, 32'h1);
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_MODE, md(k[0] ? OC_FLOW : OC_FHIGH, 1'b0, CCS_OUT, FILT_OFF));
            wr(ADDR_EVGEN, 32'h1);
            wr(ADDR_MODE, md(k[2:0], 1'b0, CCS_OUT, FILT_OFF));
            repeat (v + 10) @(posedge clk_sys);
            check(32'(chanOut[0]), 32'(k != 2), "match action");
            wr(ADDR_EVGEN, 32'h1);
            check(32'(chanOut[0]), 32'(k != 2), "update event");
        end
        // Buffered compare: the late write must not reach the shadow before the update
        wr(ADDR_MODE, md(OC_FLOW, 1'b1, CCS_OUT, FILT_OFF));
        wr(ADDR_EVGEN, 32'h1);
        wr(ADDR_MODE, md(OC_TOG, 1'b1, CCS_OUT, FILT_OFF));
        wr(ADDR_VAL0, 32'(v + 200));
        repeat (v + 10) @(posedge clk_sys);
        check(32'(chanOut[0]), 32'h1, "buffered compare");
        // Edge-aligned PWM, reload 9; includes compare 0 and compare above reload
        wr(ADDR_RELOAD, 32'h9);
        wr(ADDR_CTRL, 32'h81);
        for (int k = 0; k < 5; k++) begin
            c = (k == 0) ? 0 : (k >= 3) ? 12 : 1 + ($random(seed) & 7);
            wr(ADDR_VAL0, 32'(c));
            wr(ADDR_MODE, md(OC_FROZEN, 1'b1, CCS_OUT, FILT_OFF));
            wr(ADDR_EVGEN, 32'h1);
            wr(ADDR_MODE, md(k[0] ? OC_PWM2 : OC_PWM1, 1'b1, CCS_OUT, FILT_OFF));
            repeat (20) @(posedge clk_sys);
            h0 = highCount;
            countOn <= 1'b1;
            repeat (30) @(posedge clk_sys);
            countOn <= 1'b0;
            @(posedge clk_sys);
            c = 3 * ((c > 10) ? 10 : c);
            check(32'(highCount - h0), 32'(k[0] ? 30 - c : c), "pwm duty");
        end
        // Input capture with eight-sample filter
        wr(ADDR_RELOAD, 32'hffff);
        wr(ADDR_MODE, md(OC_FROZEN, 1'b0, 2'h1, FILT_8));
        wr(ADDR_ENABLE, 32'h0);
        wr(ADDR_EVGEN, 32'h1);
        wr(ADDR_FLAG, 32'h7);
        pin_u.drive(1'b1, 30);
        pin_u.drive(1'b0, 40);
        rdx(ADDR_FLAG, 32'h0);
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_ENABLE, 32'h1 | (32'(p) << EN_CCP));
            check(32'({chanOutEn[0], chanOut[0]}), 32'h0, "input pin idle");
            pin_u.drive(~p[0], 6);
            pin_u.drive(p[0], 40);
            rdx(ADDR_FLAG, 32'h0);
            d = 60 + ($random(seed) & 127);
            fork
                repeat (3) begin
                    pin_u.drive(~p[0], 20);
                    pin_u.drive(p[0], d - 20);
                end
                begin
                    repeat (50) @(posedge clk_sys);
                    apb(1'b0, ADDR_VAL0, 32'h0, 33'h0, 33'h0);
                    a0 = rd;
                    rdx(ADDR_FLAG, 32'h0);
                    repeat (2 * d) @(posedge clk_sys);
                    check(32'(irqReq), 32'h1, "capture irq");
                    rdx(ADDR_MISS, 32'h2);
                    wr(ADDR_VAL0, 32'h0);
                    apb(1'b0, ADDR_VAL0, 32'h0, 33'h0, 33'h0);
                    check(rd - a0, 32'(2 * d), "capture spacing");
                    rdx(ADDR_FLAG, 32'h0);
                    rdx(ADDR_MISS, 32'h2);
                    wr(ADDR_MISS, 32'h2);
                    rdx(ADDR_MISS, 32'h0);
                end
            join
        end
        // Period and width from one input on two channels, counter reset on trigger
        wr(ADDR_MODE, md(OC_FROZEN, 1'b0, 2'h1, FILT_OFF) | (32'(CCS_CROSS) << (MD_STRIDE + MD_CCS)));
        wr(ADDR_ENABLE, 32'h31);
        wr(ADDR_SLAVE, (32'(SMS_RESET) << SL_SMS) | (32'(TS_IN0) << SL_TS));
        for (int k = 0; k < 2; k++) begin
            hi[k] = 30 + k * ($random(seed) & 63);
            lo[k] = 50 + k * ($random(seed) & 63);
            repeat (3) begin
                pin_u.drive(1'b1, hi[k]);
                pin_u.drive(1'b0, lo[k]);
            end
            apb(1'b0, ADDR_VAL0, 32'h0, 33'h0, 33'h0);
            per[k] = rd;
            apb(1'b0, ADDR_VAL1, 32'h0, 33'h0, 33'h0);
            wid[k] = rd;
        end
        check(per[1] - per[0], 32'(hi[1] + lo[1] - hi[0] - lo[0]), "period");
        check(wid[1] - wid[0], 32'(hi[1] - hi[0]), "width");
        results();
    end
endmodule
`default_nettype wire
